// ==== core/omf_regs.sv ====
// Purpose: Margin, slew, droop, frequency and interleave command words with their effects
// Assumes: Command port and control inputs on clock; straps are pins
// Notes: Answer one cycle after each command; straps caught after reset release
`timescale 1ns/1ps
`default_nettype none
`include "omf_map.svh"
module omf_regs
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_page,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    input wire logic write_protect,
    output logic rsp_valid,
    output logic rsp_ack,
    output logic [15:0] rsp_rdata,
    // Straps
    input wire logic [15:0] strap_vout,
    input wire logic [15:0] strap_freq,
    input wire logic [6:0] strap_addr,
    // Per-output control
    input wire omf_pkg::omf_margin_t [1:0] margin_mode,
    input wire logic [1:0] output_on,
    input wire logic [1:0] current_share,
    input wire logic [1:0][15:0] vout_cmd,
    input wire logic [1:0][15:0] vout_max,
    input wire logic [1:0][15:0] iout,
    // Per-output results
    output logic [1:0][15:0] vout_ref,
    output logic [1:0][15:0] rate_word,
    output logic [1:0] rate_apply,
    output logic [1:0] rate_fast,
    output logic [1:0][26:0] droop_prod,
    output logic [1:0][4:0] droop_exp,
    output logic [1:0][4:0] phase_steps,
    output logic [1:0][4:0] group_num,
    // Switching frequency
    output logic [6:0] sw_div_n,
    output logic sw_div_valid
);
    import omf_pkg::*;

    logic rst_m, rst_q;
    logic [15:0] sv_m, sv_q, sf_m, sf_q;
    logic [6:0] sa_m, sa_q;
    logic [1:0] init_cnt;
    logic load, ready, hit, wr_ok, start_q;
    logic [15:0] mh [2];
    logic [15:0] ml [2];
    logic [15:0] tr [2];
    logic [15:0] dr [2];
    logic [15:0] il [2];
    logic [15:0] fsw;
    logic [15:0] next_rdata;
    logic [20:0] mh_def, ml_def;
    logic [25:0] fkhz, next_fkhz;
    logic [6:0] n_try;
    logic [32:0] prod;
    omf_fsm_t state;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_m <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_q <= rst_m;
        end
    end

    // Strap pins pass two flops before use
    always_ff @(posedge clock or negedge rst_q)
    begin
        if (!rst_q)
        begin
            sv_m <= 16'h0000;
            sv_q <= 16'h0000;
            sf_m <= 16'h0000;
            sf_q <= 16'h0000;
            sa_m <= 7'h00;
            sa_q <= 7'h00;
        end
        else
        begin
            sv_m <= strap_vout;
            sv_q <= sv_m;
            sf_m <= strap_freq;
            sf_q <= sf_m;
            sa_m <= strap_addr;
            sa_q <= sa_m;
        end
    end

    // Defaults load once the strap copies have settled; commands wait for it
    always_ff @(posedge clock or negedge rst_q)
    begin
        if (!rst_q)
            init_cnt <= 2'h0;
        else if (init_cnt != 2'h3)
            init_cnt <= init_cnt + 2'h1;
    end
    assign load = (init_cnt == 2'h2);
    assign ready = (init_cnt == 2'h3);

    // Margin defaults scaled from the strapped nominal
    assign mh_def = ({5'h00, sv_q} * `OMF_MH_NUM) / `OMF_PCT_DEN;
    assign ml_def = ({5'h00, sv_q} * `OMF_ML_NUM) / `OMF_PCT_DEN;

    // Decode of the command code
    always_comb
    begin
        case (cmd_code)
            `OMF_CMD_MARGIN_HIGH, `OMF_CMD_MARGIN_LOW, `OMF_CMD_SLEW_RATE,
            `OMF_CMD_LOAD_LINE, `OMF_CMD_SW_FREQ, `OMF_CMD_PHASE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign wr_ok = cmd_valid && cmd_write && ready && hit && !write_protect;

    // Read mux, paged words by cmd_page
    always_comb
    begin
        case (cmd_code)
            `OMF_CMD_MARGIN_HIGH: next_rdata = mh[cmd_page];
            `OMF_CMD_MARGIN_LOW: next_rdata = ml[cmd_page];
            `OMF_CMD_SLEW_RATE: next_rdata = tr[cmd_page];
            `OMF_CMD_LOAD_LINE: next_rdata = dr[cmd_page];
            `OMF_CMD_SW_FREQ: next_rdata = fsw;
            `OMF_CMD_PHASE: next_rdata = il[cmd_page];
            default: next_rdata = 16'h0000;
        endcase
    end

    // Answer: ack for a taken write or a mapped read, nack otherwise
    always_ff @(posedge clock or negedge rst_q)
    begin
        if (!rst_q)
        begin
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_rdata <= 16'h0000;
        end
        else
        begin
            rsp_valid <= cmd_valid;
            rsp_ack <= cmd_valid && (cmd_write ? wr_ok : (ready && hit));
            rsp_rdata <= (cmd_valid && !cmd_write && ready) ? next_rdata : 16'h0000;
        end
    end

    // Global frequency word; strap first, writes override
    always_ff @(posedge clock or negedge rst_q)
    begin
        if (!rst_q)
        begin
            fsw <= 16'h0000;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= load || (wr_ok && cmd_code == `OMF_CMD_SW_FREQ);
            if (load)
                fsw <= sf_q;
            else if (wr_ok && cmd_code == `OMF_CMD_SW_FREQ)
                fsw <= cmd_wdata;
        end
    end

    // Linear-11 to kHz; negative values count as zero
    always_comb
    begin
        next_fkhz = 26'h0000000;
        if (!fsw[10])
        begin
            if (!fsw[15])
                next_fkhz = {16'h0000, fsw[9:0]} << fsw[14:11];
            else
                next_fkhz = {16'h0000, fsw[9:0]} >> (5'h00 - fsw[15:11]);
        end
    end
    assign prod = 33'(n_try * fkhz);

    // Divider search: smallest n from 11 whose 16 MHz / n does not exceed the word, else 80
    always_ff @(posedge clock or negedge rst_q)
    begin
        if (!rst_q)
        begin
            state <= OMF_IDLE;
            fkhz <= 26'h0000000;
            n_try <= `OMF_N_MIN;
            sw_div_n <= `OMF_N_MAX;
            sw_div_valid <= 1'b0;
        end
        else if (start_q)
        begin
            state <= OMF_SEARCH;
            fkhz <= next_fkhz;
            n_try <= `OMF_N_MIN;
            sw_div_valid <= 1'b0;
        end
        else
        begin
            case (state)
                OMF_IDLE: state <= OMF_IDLE;
                OMF_SEARCH:
                begin
                    if (prod >= `OMF_FSW_BASE_KHZ || n_try == `OMF_N_MAX)
                    begin
                        sw_div_n <= n_try;
                        sw_div_valid <= 1'b1;
                        state <= OMF_IDLE;
                    end
                    else
                        n_try <= n_try + 7'h01;
                end
                default: state <= OMF_IDLE;
            endcase
        end
    end

    // Per-output words and their effects
    for (genvar p = 0; p < 2; p++)
    begin : g_out
        logic on_q;
        omf_margin_t mode_q;
        logic [15:0] tgt;

        // Paged words: defaults at load, then bus writes
        always_ff @(posedge clock or negedge rst_q)
        begin
            if (!rst_q)
            begin
                mh[p] <= 16'h0000;
                ml[p] <= 16'h0000;
                tr[p] <= `OMF_RATE_RST;
                dr[p] <= `OMF_DROOP_RST;
                il[p] <= 16'h0000;
            end
            else if (load)
            begin
                mh[p] <= mh_def[15:0];
                ml[p] <= ml_def[15:0];
                tr[p] <= `OMF_RATE_RST;
                dr[p] <= `OMF_DROOP_RST;
                il[p] <= {8'h00, sa_q[3:0], sa_q[3:0]};
            end
            else if (wr_ok && cmd_page == p)
            begin
                case (cmd_code)
                    `OMF_CMD_MARGIN_HIGH: mh[p] <= cmd_wdata;
                    `OMF_CMD_MARGIN_LOW: ml[p] <= cmd_wdata;
                    `OMF_CMD_SLEW_RATE: tr[p] <= cmd_wdata;
                    `OMF_CMD_LOAD_LINE: dr[p] <= cmd_wdata;
                    `OMF_CMD_PHASE: il[p] <= {8'h00, cmd_wdata[7:0]};
                    default: il[p] <= il[p];
                endcase
            end
        end

        // Target select; words are 2^-13 V units, same scale as the maximum
        always_comb
        begin
            case (margin_mode[p])
                OMF_MARGIN_HIGH: tgt = mh[p];
                OMF_MARGIN_LOW: tgt = ml[p];
                default: tgt = vout_cmd[p];
            endcase
        end

        // Clamp, slew and droop results
        always_ff @(posedge clock or negedge rst_q)
        begin
            if (!rst_q)
            begin
                vout_ref[p] <= 16'h0000;
                rate_word[p] <= `OMF_RATE_RST;
                rate_fast[p] <= 1'b0;
                droop_prod[p] <= 27'h0000000;
                droop_exp[p] <= 5'h00;
            end
            else
            begin
                vout_ref[p] <= (tgt > vout_max[p]) ? vout_max[p] : tgt;
                rate_word[p] <= tr[p];
                rate_fast[p] <= (tr[p] == `OMF_RATE_FAST);
                // Signed product keeps the sign, so sinking current raises the output
                droop_prod[p] <= 27'($signed(dr[p][10:0]) * $signed(iout[p]));
                droop_exp[p] <= dr[p][15:11];
            end
        end

        // Rate applies only to mode changes while steadily on, never to on/off ramps
        always_ff @(posedge clock or negedge rst_q)
        begin
            if (!rst_q)
            begin
                on_q <= 1'b0;
                mode_q <= OMF_NOMINAL;
                rate_apply[p] <= 1'b0;
            end
            else
            begin
                on_q <= output_on[p];
                mode_q <= margin_mode[p];
                if (!output_on[p])
                    rate_apply[p] <= 1'b0;
                else if (on_q && margin_mode[p] != mode_q)
                    rate_apply[p] <= 1'b1;
            end
        end

        // Interleave fields, zero means sixteen; sharing rails take no offset here
        always_ff @(posedge clock or negedge rst_q)
        begin
            if (!rst_q)
            begin
                phase_steps[p] <= 5'h00;
                group_num[p] <= 5'h00;
            end
            else
            begin
                phase_steps[p] <= current_share[p] ? 5'h00 : {il[p][3:0] == 4'h0, il[p][3:0]};
                group_num[p] <= {il[p][7:4] == 4'h0, il[p][7:4]};
            end
        end

        a_clamp_max: assert property (@(posedge clock) disable iff (!rst_q)
            vout_ref[p] <= $past(vout_max[p])) else $error("target above maximum");
        a_high_sel: assert property (@(posedge clock) disable iff (!rst_q)
            margin_mode[p] == OMF_MARGIN_HIGH && mh[p] <= vout_max[p] |=> vout_ref[p] == $past(mh[p]))
            else $error("margin high not used");
        a_low_sel: assert property (@(posedge clock) disable iff (!rst_q)
            margin_mode[p] == OMF_MARGIN_LOW && ml[p] <= vout_max[p] |=> vout_ref[p] == $past(ml[p]))
            else $error("margin low not used");
        a_ramp_off: assert property (@(posedge clock) disable iff (!rst_q)
            !output_on[p] ##1 output_on[p] |=> !rate_apply[p]) else $error("rate on turn-on");
        a_phase_share: assert property (@(posedge clock) disable iff (!rst_q)
            current_share[p] |=> phase_steps[p] == 5'h00) else $error("sharing rail offset");
        a_load_defaults: assert property (@(posedge clock) disable iff (!rst_q)
            load |=> tr[p] == `OMF_RATE_RST && dr[p] == 16'h0000 && il[p][15:8] == 8'h00
            && il[p][7:4] == il[p][3:0]) else $error("bad reset defaults");
        c_margin_high: cover property (@(posedge clock) disable iff (!rst_q)
            output_on[p] && rate_apply[p] && margin_mode[p] == OMF_MARGIN_HIGH);
    end

    a_wp_refuse: assert property (@(posedge clock) disable iff (!rst_q)
        cmd_valid && cmd_write && write_protect |=> rsp_valid && !rsp_ack) else $error("write taken");
    a_div_range: assert property (@(posedge clock) disable iff (!rst_q)
        sw_div_valid |-> sw_div_n >= `OMF_N_MIN && sw_div_n <= `OMF_N_MAX) else $error("divider range");
    a_div_time: assert property (@(posedge clock) disable iff (!rst_q)
        start_q |-> ##[1:72] sw_div_valid) else $error("divider search stuck");
    a_freq_write: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ok && cmd_code == `OMF_CMD_SW_FREQ |=> fsw == $past(cmd_wdata) ##1 !sw_div_valid)
        else $error("frequency write lost");
    c_write_ack: cover property (@(posedge clock) disable iff (!rst_q) wr_ok ##1 rsp_ack);
    c_refused: cover property (@(posedge clock) disable iff (!rst_q) rsp_valid && !rsp_ack);
    c_div_done: cover property (@(posedge clock) disable iff (!rst_q) state == OMF_SEARCH ##1 sw_div_valid);
endmodule
`default_nettype wire

// ==== core/omf_map.svh ====
// Purpose: Command codes, reset values and constants of the margin/frequency config bank
// Assumes: Command codes are the one-byte bus command numbers
// Notes: Included by omf_regs and omf_regs_tb
// Behaviour
// - Per-output margin-high word at 25h, used when margin-high is selected
// - Per-output margin-low word at 26h, used when margin-low is selected
// - Margin-high word is unsigned volts times two to minus thirteen
// - Margin-high defaults to 1.05 times strapped nominal output voltage
// - Margin-low defaults to 0.95 times strapped nominal output voltage
// - Word at 27h is the slew rate for margin changes
// - Largest positive rate word means change as fast as possible
// - Rate is not applied to turn-on or turn-off ramps
// - Rate word is linear-11, resets to ba00h, range 0.1 to 4 V/ms
// - Output drops with current by droop slope held at 28h
// - Negative current keeps droop applied, raising output above nominal
// - Droop word resets to zero, supported range 0 to 40 mV/A
// - Switching frequency is 16 MHz divided by n, n from 11 to 80
// - Global frequency word at 33h, strapped default, overridden by writes
// - Interleave at 37h: zero bits 15:8, group 7:4, position 3:0, zero means 16
// - Phase delayed 22.5 degrees per position step, position 1 is 22.5
// - Current-sharing rails ignore interleave, use current-share phase config; here sharing zeroes only phase_steps, group_num still follows bits 7:4
// - Interleave resets to address low nibble in both group and position
// - Targets above the programmed maximum regulate to the maximum
`ifndef OMF_MAP_SVH
`define OMF_MAP_SVH
`define OMF_CMD_MARGIN_HIGH 8'h25
`define OMF_CMD_MARGIN_LOW 8'h26
`define OMF_CMD_SLEW_RATE 8'h27
`define OMF_CMD_LOAD_LINE 8'h28
`define OMF_CMD_SW_FREQ 8'h33
`define OMF_CMD_PHASE 8'h37
`define OMF_RATE_RST 16'hba00
`define OMF_DROOP_RST 16'h0000
`define OMF_RATE_FAST 16'h7bff
`define OMF_MH_NUM 21'h000015
`define OMF_ML_NUM 21'h000013
`define OMF_PCT_DEN 21'h000014
`define OMF_FSW_BASE_KHZ 33'h000003e80
`define OMF_N_MIN 7'h0b
`define OMF_N_MAX 7'h50
`endif

// ==== core/omf_pkg.sv ====
// Purpose: Types of the margin/frequency config bank
// Assumes: Two outputs
// Notes: Constants live in omf_map.svh
package omf_pkg;
    typedef enum logic [1:0] {OMF_NOMINAL, OMF_MARGIN_LOW, OMF_MARGIN_HIGH} omf_margin_t;
    typedef enum logic {OMF_IDLE, OMF_SEARCH} omf_fsm_t;
endpackage

// ==== sim/omf_host.sv ====
// Purpose: Bus host model that issues one command word at a time
// Assumes: Inputs change on the falling edge, answer one cycle later
// Notes: Releases qualifiers to inverted values between commands
`timescale 1ns/1ps
`default_nettype none
module omf_host
(
    // Clock
    input wire logic clock,
    // Command side
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_page,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    // Answer side
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    input wire logic [15:0] rsp_rdata
);
    logic seen;

    // Idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_page = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        seen = 1'b0;
    end

    // Caller keeps frequency writes to times the outputs are off
    task automatic do_cmd(input logic wr, input logic pg, input logic [7:0] code,
        input logic [15:0] wd, output logic ok, output logic [15:0] rd);
    begin
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_page = pg;
        cmd_code = code;
        cmd_wdata = wd;
        @(negedge clock);
        // Answer stands only in this cycle
        seen = rsp_valid;
        ok = rsp_ack;
        rd = rsp_rdata;
        cmd_valid = 1'b0;
        // Stale qualifiers must not look like the last command
        cmd_write = ~cmd_write;
        cmd_page = ~cmd_page;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
    end
    endtask
endmodule
`default_nettype wire

// ==== sim/omf_regs_tb.sv ====
// Purpose: Self-checking bench of the margin and frequency command bank
// Assumes: Host model drives commands; bench drives straps and controls
// Notes: Expected values come from the strap and write values used here
`timescale 1ns/1ps
`default_nettype none
`include "omf_map.svh"
module omf_regs_tb;
    import omf_pkg::*;
    logic clock, rst_n, cmd_valid, cmd_write, cmd_page, write_protect, rsp_valid, rsp_ack, sw_div_valid;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata, strap_vout, strap_freq;
    logic [6:0] strap_addr, sw_div_n;
    omf_margin_t [1:0] margin_mode;
    logic [1:0] output_on, current_share, rate_apply, rate_fast;
    logic [1:0][15:0] vout_cmd, vout_max, iout, vout_ref, rate_word;
    logic [1:0][26:0] droop_prod;
    logic [1:0][4:0] droop_exp, phase_steps, group_num;
    int miscompares = 0;
    int cmp_count = 0;
    localparam logic [15:0] MH_DEF = 16'((32'h2000 * 32'h15) / 32'h14);
    localparam logic [15:0] ML_DEF = 16'((32'h2000 * 32'h13) / 32'h14);

    omf_host u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_page(cmd_page),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
        .rsp_rdata(rsp_rdata));
    omf_regs u_dut (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .write_protect(write_protect),
        .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .strap_vout(strap_vout),
        .strap_freq(strap_freq), .strap_addr(strap_addr), .margin_mode(margin_mode),
        .output_on(output_on), .current_share(current_share), .vout_cmd(vout_cmd), .vout_max(vout_max),
        .iout(iout), .vout_ref(vout_ref), .rate_word(rate_word), .rate_apply(rate_apply),
        .rate_fast(rate_fast), .droop_prod(droop_prod), .droop_exp(droop_exp),
        .phase_steps(phase_steps), .group_num(group_num), .sw_div_n(sw_div_n),
        .sw_div_valid(sw_div_valid));

    // Free-running 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic finish_test;
    begin
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic wr(input logic pg, input logic [7:0] c, input logic [15:0] d, input logic exp_ok);
        logic ok;
        logic [15:0] rd;
    begin
        u_host.do_cmd(1'b1, pg, c, d, ok, rd);
        chk(u_host.seen, 1'b1);
        chk(ok, exp_ok);
        // Let the result outputs settle
        @(negedge clock);
    end
    endtask

    task automatic rdchk(input logic pg, input logic [7:0] c, input logic [15:0] e);
        logic ok;
        logic [15:0] rd;
    begin
        u_host.do_cmd(1'b0, pg, c, 16'h0000, ok, rd);
        chk(ok, 1'b1);
        chk(rd, e);
    end
    endtask

    // Divider drops valid, then searches; a stuck search ends the run
    task automatic wait_div;
    begin
        @(negedge clock);
        for (int i = 0; i < 100; i++)
        begin
            if (sw_div_valid === 1'b1)
                return;
            @(negedge clock);
        end
        miscompares++;
        $display("mismatch at %0t: divider never settled", $time);
        finish_test();
    end
    endtask

    task automatic t_defaults;
    begin
        for (int p = 0; p < 2; p++)
        begin
            rdchk(p[0], `OMF_CMD_MARGIN_HIGH, MH_DEF);
            rdchk(p[0], `OMF_CMD_MARGIN_LOW, ML_DEF);
            rdchk(p[0], `OMF_CMD_SLEW_RATE, 16'hba00);
            rdchk(p[0], `OMF_CMD_LOAD_LINE, 16'h0000);
            rdchk(p[0], `OMF_CMD_PHASE, 16'h00bb);
            chk(group_num[p], 5'h0b);
            chk(phase_steps[p], 5'h0b);
        end
        rdchk(1'b1, `OMF_CMD_SW_FREQ, 16'h0190);
        chk(sw_div_n, 7'h28);
    end
    endtask

    task automatic t_margin;
    begin
        chk(vout_ref[0], 16'h2000);
        wr(1'b0, `OMF_CMD_MARGIN_HIGH, 16'h2800, 1'b1);
        margin_mode[0] = OMF_MARGIN_HIGH;
        repeat (2) @(negedge clock);
        chk(vout_ref[0], 16'h2800);
        chk(vout_ref[1], 16'h1000);
        wr(1'b0, `OMF_CMD_MARGIN_HIGH, 16'h4000, 1'b1);
        chk(vout_ref[0], 16'h3000);
        margin_mode[0] = OMF_MARGIN_LOW;
        repeat (2) @(negedge clock);
        chk(vout_ref[0], ML_DEF);
        wr(1'b0, `OMF_CMD_MARGIN_LOW, 16'h1800, 1'b1);
        chk(vout_ref[0], 16'h1800);
    end
    endtask

    task automatic t_rate;
    begin
        output_on[1] = 1'b1;
        repeat (3) @(negedge clock);
        chk(rate_apply[1], 1'b0);
        margin_mode[1] = OMF_MARGIN_HIGH;
        repeat (2) @(negedge clock);
        chk(rate_apply[1], 1'b1);
        output_on[1] = 1'b0;
        repeat (2) @(negedge clock);
        chk(rate_apply[1], 1'b0);
        wr(1'b1, `OMF_CMD_SLEW_RATE, 16'h7bff, 1'b1);
        chk(rate_word[1], 16'h7bff);
        chk(rate_fast, 2'b10);
        wr(1'b1, `OMF_CMD_SLEW_RATE, 16'h7bfe, 1'b1);
        chk(rate_fast[1], 1'b0);
    end
    endtask

    task automatic t_droop;
    begin
        iout[0] = 16'hfffd;
        wr(1'b0, `OMF_CMD_LOAD_LINE, 16'hf805, 1'b1);
        chk(droop_prod[0], 27'h7fffff1);
        chk(droop_exp[0], 5'h1f);
        iout[0] = 16'h0004;
        repeat (2) @(negedge clock);
        chk(droop_prod[0], 27'h0000014);
        rdchk(1'b0, `OMF_CMD_LOAD_LINE, 16'hf805);
    end
    endtask

    task automatic t_freq;
        logic [15:0] fw [4] = '{16'h0190, 16'h0be8, 16'h00c8, 16'h0400};
        logic [6:0] fn [4] = '{7'h28, 7'h0b, 7'h50, 7'h50};
    begin
        // Outputs off while the frequency changes
        output_on = 2'b00;
        for (int i = 0; i < 4; i++)
        begin
            wr(1'b0, `OMF_CMD_SW_FREQ, fw[i], 1'b1);
            wait_div();
            chk(sw_div_n, fn[i]);
        end
    end
    endtask

    task automatic t_protect;
        logic ok;
        logic [15:0] rd;
    begin
        write_protect = 1'b1;
        wr(1'b1, `OMF_CMD_MARGIN_HIGH, 16'hbeef, 1'b0);
        wr(1'b0, `OMF_CMD_SW_FREQ, 16'h0be8, 1'b0);
        repeat (3) @(negedge clock);
        chk(sw_div_n, 7'h50);
        write_protect = 1'b0;
        rdchk(1'b1, `OMF_CMD_MARGIN_HIGH, MH_DEF);
        u_host.do_cmd(1'b0, 1'b0, 8'h99, 16'h0000, ok, rd);
        chk({ok, rd}, 17'h00000);
    end
    endtask

    task automatic t_phase;
    begin
        wr(1'b0, `OMF_CMD_PHASE, 16'hff30, 1'b1);
        rdchk(1'b0, `OMF_CMD_PHASE, 16'h0030);
        chk(group_num[0], 5'h03);
        chk(phase_steps[0], 5'h10);
        wr(1'b0, `OMF_CMD_PHASE, 16'h0005, 1'b1);
        chk(group_num[0], 5'h10);
        chk(phase_steps[0], 5'h05);
        current_share[0] = 1'b1;
        repeat (2) @(negedge clock);
        chk(phase_steps[0], 5'h00);
    end
    endtask

    // Mid-run reset must bring back strapped defaults, not keep the written words
    task automatic t_reset;
    begin
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        wait_div();
        rdchk(1'b0, `OMF_CMD_MARGIN_HIGH, MH_DEF);
        rdchk(1'b0, `OMF_CMD_PHASE, 16'h00bb);
        chk(sw_div_n, 7'h28);
    end
    endtask

    // Main sequence: reset, then one scenario after another
    initial
    begin
        rst_n = 1'b0;
        write_protect = 1'b0;
        strap_vout = 16'h2000;
        strap_freq = 16'h0190;
        strap_addr = 7'h2b;
        margin_mode = '{OMF_NOMINAL, OMF_NOMINAL};
        output_on = 2'b00;
        current_share = 2'b00;
        vout_cmd = {16'h1000, 16'h2000};
        vout_max = {16'hffff, 16'h3000};
        iout = {16'h0000, 16'h0000};
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        wait_div();
        t_defaults();
        t_margin();
        t_rate();
        t_droop();
        t_freq();
        t_protect();
        t_phase();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
